/* logic/virs_pkg.sv */
package virs_pkg;

   // Program address width; the program space is 32 kbytes.
   localparam int ADDR_W = 15;
   // Number of maskable vector slots between the default slot and the trap slot.
   localparam int MASK_N = 14;
   // Width of a vector slot number (16 slots).
   localparam int SLOT_W = 4;

   // Common entry address that every acknowledge jumps to.
   localparam logic [ADDR_W-1:0] ENTRY_ADDR = 15'h00ff;

   // Acknowledge length in instruction cycles, and the last count value.
   localparam int ACK_CYCLES = 7;
   localparam logic [2:0] ACK_LAST = 3'(ACK_CYCLES - 1);

   // Vector table layout inside a 256-byte block.
   localparam logic [7:0] TABLE_LOW_BASE = 8'he0;
   localparam logic [7:0] BLOCK_LAST_BYTE = 8'hff;
   localparam logic [6:0] BLOCK_STEP = 7'h01;
   localparam logic [7:0] BYTE_STEP = 8'h01;

   // Slot numbers of the two fixed ends of the table.
   localparam logic [SLOT_W-1:0] SLOT_DEFAULT = 4'h0;
   localparam logic [SLOT_W-1:0] SLOT_TRAP = 4'hf;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      VIRS_IDLE = 4'b0001,
      VIRS_ACK = 4'b0010,
      VIRS_VEC_HI = 4'b0100,
      VIRS_VEC_LO = 4'b1000
   } virs_state_t;

endpackage

/* logic/virs_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none

// How it works
// - A skip due at the boundary is done by the core before a maskable acknowledge; a trap acknowledge does not wait for it.
// - A maskable acknowledge start clears global_irq_enable; a trap acknowledge leaves it unchanged.
// - Acknowledge pushes the address of the instruction due next.
// - Acknowledge ends by loading the program counter with the common entry.
// - The acknowledge sequence lasts exactly seven instruction cycles.
// - A status word write setting global_irq_enable re-enables maskable interrupts.
// - return_from_interrupt sets global_irq_enable and loads the popped address.
// - Pending enabled sources are acknowledged right after return_from_interrupt.
// - Boot ROM execution blocks maskable interrupts (a trap acknowledge still starts) but keeps global_irq_enable unchanged.
// - During in_system_programming only one event per source is kept.
// - vector_interrupt_select jumps through the highest enabled pending source's vector.
// - The 32-byte table sits at the top of the opcode's 256-byte block.
// - An opcode on a block's last byte uses the next block's table.
// - Vectors are 15-bit targets in a 32-kbyte space.
// - The high vector byte is read first, from the lower address.
// - Slots rise by rank from E0/E1 in steps of two bytes.
// - The software trap always uses the top two table bytes.
// - Highest priority is served first, the next after its return.
// - With nothing enabled and pending the default lowest slot is used.
// - Maskable interrupts need boundary, enable, pending, global enable, no trap service.
// - Reset clears all pending flags, enables and global_irq_enable.
// - The table offset replaces the program counter's low byte; the high part steps only for an opcode on a block's last byte.
module virs_sequencer #(
   parameter int MASK_N = virs_pkg::MASK_N
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic insn_boundary,
   input wire logic skip_due,
   input wire logic [virs_pkg::ADDR_W-1:0] next_pc,
   input wire logic boot_rom_exec,
   input wire logic isp_active,
   input wire logic [MASK_N-1:0] src_event,
   input wire logic [MASK_N-1:0] pend_clear,
   input wire logic enable_wr,
   input wire logic [MASK_N-1:0] enable_data,
   input wire logic status_wr,
   input wire logic status_gie_data,
   input wire logic trap_event,
   input wire logic trap_pend_clear,
   input wire logic return_from_interrupt_exec,
   input wire logic [virs_pkg::ADDR_W-1:0] pop_addr,
   input wire logic vsel_exec,
   input wire logic [virs_pkg::ADDR_W-1:0] vsel_pc,
   input wire logic fetch_ack,
   input wire logic [7:0] fetch_data,
   output logic global_irq_enable,
   output logic [MASK_N-1:0] pending,
   output logic [MASK_N-1:0] enable,
   output logic trap_pending,
   output logic seq_busy,
   output logic push_req,
   output logic [virs_pkg::ADDR_W-1:0] push_addr,
   output logic pc_load,
   output logic [virs_pkg::ADDR_W-1:0] pc_value,
   output logic fetch_req,
   output logic [virs_pkg::ADDR_W-1:0] fetch_addr
);
   import virs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   virs_state_t state_reg;
   logic gie_reg;
   logic [MASK_N-1:0] pend_reg;
   logic [MASK_N-1:0] en_reg;
   logic trap_pend_reg;
   logic [2:0] cnt_reg;
   logic seq_busy_reg;
   logic push_req_reg;
   logic [ADDR_W-1:0] push_addr_reg;
   logic pc_load_reg;
   logic [ADDR_W-1:0] pc_value_reg;
   logic fetch_req_reg;
   logic [ADDR_W-1:0] fetch_addr_reg;
   logic [6:0] vec_hi_reg;
   logic [MASK_N-1:0] active;
   logic irq_take;
   logic ack_start;
   logic [SLOT_W-1:0] win_slot;
   logic [ADDR_W-1:0] table_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration helpers.

   // Highest ranked slot; the trap outranks every maskable source.
   function automatic logic [SLOT_W-1:0] top_slot(input logic [MASK_N-1:0] act,
                                                 input logic trap);
      logic [SLOT_W-1:0] s;
      s = SLOT_DEFAULT;
      for (int i = 0; i < MASK_N; i++) begin
         if (act[i]) begin
            s = SLOT_W'(i + 1);
         end
      end
      if (trap) begin
         s = SLOT_TRAP;
      end
      return s;
   endfunction

   // Address of a slot's high byte, in the table block chosen by the opcode address.
   function automatic logic [ADDR_W-1:0] slot_addr(input logic [ADDR_W-1:0] pc,
                                                  input logic [SLOT_W-1:0] slot);
      logic [6:0] blk;
      blk = pc[ADDR_W-1:8];
      if (pc[7:0] == BLOCK_LAST_BYTE) begin
         blk = blk + BLOCK_STEP;
      end
      return {blk, TABLE_LOW_BASE + {3'h0, slot, 1'b0}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Take decision; a maskable take is evaluated at an instruction boundary only.

   assign active = pend_reg & en_reg;
   // A skip is left to the core; the boundary after it sees the request again.
   assign irq_take = insn_boundary && !skip_due && !boot_rom_exec &&
                     gie_reg && (|active) && !trap_pend_reg;
   // A trap instruction starts the same sequence without regard to the global enable.
   assign ack_start = (state_reg == VIRS_IDLE) && (irq_take || trap_event);
   assign win_slot = top_slot(active, trap_pend_reg);
   assign table_addr = slot_addr(vsel_pc, win_slot);

   ////////////////////////////////////////////////////////////////////////////
   // Pending flags; a set in the same cycle as a clear wins so no event is lost.
   // Being one bit per source, repeats while pending collapse into one occurrence.

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~pend_clear) | src_event;
      end
   end

   // Individual enables, written whole by the core.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         en_reg <= '0;
      end else if (enable_wr) begin
         en_reg <= enable_data;
      end
   end

   // Trap pending flag; only the reset-pending instruction or reset clears it.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         trap_pend_reg <= 1'b0;
      end else if (trap_event) begin
         trap_pend_reg <= 1'b1;
      end else if (trap_pend_clear) begin
         trap_pend_reg <= 1'b0;
      end
   end

   // Global enable; the acknowledge clear outranks a same-cycle status write,
   // since a routine being entered must not be preempted.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gie_reg <= 1'b0;
      end else if (irq_take && state_reg == VIRS_IDLE) begin
         gie_reg <= 1'b0;
      end else if (return_from_interrupt_exec) begin
         gie_reg <= 1'b1;
      end else if (status_wr) begin
         gie_reg <= status_gie_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: acknowledge, and the two-byte vector fetch.

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= VIRS_IDLE;
         cnt_reg <= '0;
         seq_busy_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            VIRS_IDLE: begin
               cnt_reg <= '0;
               seq_busy_reg <= ack_start || vsel_exec;
               if (ack_start) begin
                  state_reg <= VIRS_ACK;
               end else if (vsel_exec) begin
                  state_reg <= VIRS_VEC_HI;
               end
            end
            VIRS_ACK: begin
               if (cnt_reg == ACK_LAST) begin
                  state_reg <= VIRS_IDLE;
                  seq_busy_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg + 3'h1;
               end
            end
            VIRS_VEC_HI: begin
               if (fetch_ack) begin
                  state_reg <= VIRS_VEC_LO;
               end
            end
            VIRS_VEC_LO: begin
               if (fetch_ack) begin
                  state_reg <= VIRS_IDLE;
                  seq_busy_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   // Return address push, one pulse at the first acknowledge cycle.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         push_req_reg <= 1'b0;
         push_addr_reg <= '0;
      end else begin
         push_req_reg <= ack_start;
         if (ack_start) begin
            push_addr_reg <= next_pc;
         end
      end
   end

   // Program counter loads: entry at acknowledge end, popped address on return,
   // and the fetched vector after the low byte arrives.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pc_load_reg <= 1'b0;
         pc_value_reg <= '0;
      end else begin
         pc_load_reg <= 1'b0;
         if (state_reg == VIRS_ACK && cnt_reg == ACK_LAST) begin
            pc_load_reg <= 1'b1;
            pc_value_reg <= ENTRY_ADDR;
         end else if (state_reg == VIRS_VEC_LO && fetch_ack) begin
            pc_load_reg <= 1'b1;
            pc_value_reg <= {vec_hi_reg, fetch_data};
         end else if (state_reg == VIRS_IDLE && return_from_interrupt_exec && !ack_start) begin
            pc_load_reg <= 1'b1;
            pc_value_reg <= pop_addr;
         end
      end
   end

   // Vector byte fetch; the offset is frozen at the first cycle of the select.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fetch_req_reg <= 1'b0;
         fetch_addr_reg <= '0;
      end else if (state_reg == VIRS_IDLE && !ack_start && vsel_exec) begin
         fetch_req_reg <= 1'b1;
         fetch_addr_reg <= table_addr;
      end else if (state_reg == VIRS_VEC_HI && fetch_ack) begin
         fetch_addr_reg <= fetch_addr_reg + {7'h00, BYTE_STEP};
      end else if (state_reg == VIRS_VEC_LO && fetch_ack) begin
         fetch_req_reg <= 1'b0;
      end
   end

   // High vector byte; its top bit is dropped since targets are 15 bits.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         vec_hi_reg <= '0;
      end else if (state_reg == VIRS_VEC_HI && fetch_ack) begin
         vec_hi_reg <= fetch_data[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops.

   assign global_irq_enable = gie_reg;
   assign pending = pend_reg;
   assign enable = en_reg;
   assign trap_pending = trap_pend_reg;
   assign seq_busy = seq_busy_reg;
   assign push_req = push_req_reg;
   assign push_addr = push_addr_reg;
   assign pc_load = pc_load_reg;
   assign pc_value = pc_value_reg;
   assign fetch_req = fetch_req_reg;
   assign fetch_addr = fetch_addr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_skip_first;
      @(posedge clock) disable iff (reset)
      (insn_boundary && skip_due && !trap_event && state_reg == VIRS_IDLE) |=> !push_req;
   endproperty
   a_skip_first: assert property (p_skip_first) else $error("ack during skip");

   property p_gie_clear;
      @(posedge clock) disable iff (reset)
      (irq_take && state_reg == VIRS_IDLE) |=> !global_irq_enable;
   endproperty
   a_gie_clear: assert property (p_gie_clear) else $error("gie kept on ack");

   property p_push_addr;
      @(posedge clock) disable iff (reset)
      ack_start |=> (push_req && push_addr == $past(next_pc));
   endproperty
   a_push_addr: assert property (p_push_addr) else $error("bad push");

   property p_ack_len;
      @(posedge clock) disable iff (reset)
      ack_start |=> (!pc_load) [*7] ##1 (pc_load && pc_value == ENTRY_ADDR);
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack not seven cycles");

   property p_status_set;
      @(posedge clock) disable iff (reset)
      (status_wr && status_gie_data && !return_from_interrupt_exec && !ack_start) |=> global_irq_enable;
   endproperty
   a_status_set: assert property (p_status_set) else $error("gie not set");

   property p_return_from_interrupt;
      @(posedge clock) disable iff (reset)
      (return_from_interrupt_exec && state_reg == VIRS_IDLE && !ack_start) |=>
         (global_irq_enable && pc_load && pc_value == $past(pop_addr));
   endproperty
   a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("bad return");

   property p_boot_block;
      @(posedge clock) disable iff (reset)
      (boot_rom_exec && !trap_event && !status_wr && !return_from_interrupt_exec) |=>
         (!push_req && $stable(global_irq_enable));
   endproperty
   a_boot_block: assert property (p_boot_block) else $error("boot rom not blocking");

   property p_vec_addr;
      @(posedge clock) disable iff (reset)
      (vsel_exec && state_reg == VIRS_IDLE && !ack_start && vsel_pc[7:0] != BLOCK_LAST_BYTE) |=>
         (fetch_req && fetch_addr[ADDR_W-1:8] == $past(vsel_pc[ADDR_W-1:8]) &&
          fetch_addr[7:0] >= TABLE_LOW_BASE && !fetch_addr[0]);
   endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("bad table address");

   property p_vec_jump;
      @(posedge clock) disable iff (reset)
      (state_reg == VIRS_VEC_LO && fetch_ack) |=>
         (pc_load && pc_value == {vec_hi_reg, $past(fetch_data)} && !fetch_req);
   endproperty
   a_vec_jump: assert property (p_vec_jump) else $error("bad vector jump");

   property p_trap_slot;
      @(posedge clock) disable iff (reset)
      (vsel_exec && state_reg == VIRS_IDLE && !ack_start && trap_pend_reg) |=>
         (fetch_addr[7:0] == (TABLE_LOW_BASE + {3'h0, SLOT_TRAP, 1'b0}));
   endproperty
   a_trap_slot: assert property (p_trap_slot) else $error("trap slot wrong");

   property p_isp_once;
      @(posedge clock) disable iff (reset)
      (isp_active && |src_event) |=> ((pending & $past(src_event)) == $past(src_event));
   endproperty
   a_isp_once: assert property (p_isp_once) else $error("isp event not held");

endmodule

`default_nettype wire

/* verif/virs_prog_mem.sv */
`timescale 1ns/1ns
`default_nettype none

// Program memory beside the sequencer: answers each vector fetch after a chosen stall.
module virs_prog_mem (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] stall,
   input wire logic fetch_req,
   input wire logic [virs_pkg::ADDR_W-1:0] fetch_addr,
   output logic fetch_ack,
   output logic [7:0] fetch_data
);
   import virs_pkg::*;
   logic [3:0] wait_reg;

   // Even bytes carry a set top bit, so a target that keeps it stands out.
   function automatic logic [7:0] rom(input logic [ADDR_W-1:0] a);
      return a[0] ? (a[7:0] ^ 8'h3c) : (a[7:0] | 8'h80);
   endfunction

   // One-cycle answer per byte; outside it the data is inverted every cycle,
   // because a late sample must never see the byte just delivered.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         fetch_ack <= 1'b0;
         fetch_data <= 8'h00;
         wait_reg <= 4'h0;
      end else if (fetch_req && !fetch_ack && wait_reg >= stall) begin
         fetch_ack <= 1'b1;
         fetch_data <= rom(fetch_addr);
         wait_reg <= 4'h0;
      end else begin
         fetch_ack <= 1'b0;
         fetch_data <= ~fetch_data;
         wait_reg <= (fetch_req && !fetch_ack) ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

/* verif/virs_sequencer_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module virs_sequencer_bench;
   import virs_pkg::*;
   logic clock = 1'b0, reset = 1'b1, insn_boundary = 1'b0, skip_due = 1'b0;
   logic boot_rom_exec = 1'b0, isp_active = 1'b0, enable_wr = 1'b0, status_wr = 1'b0;
   logic status_gie_data = 1'b0, trap_event = 1'b0, trap_pend_clear = 1'b0;
   logic return_from_interrupt_exec = 1'b0, vsel_exec = 1'b0, fetch_ack, push_req, pc_load, fetch_req;
   logic global_irq_enable, trap_pending, seq_busy;
   logic [13:0] src_event = '0, pend_clear = '0, enable_data = '0, pending, enable;
   logic [ADDR_W-1:0] next_pc = '0, pop_addr = '0, vsel_pc = '0;
   logic [ADDR_W-1:0] push_addr, pc_value, fetch_addr;
   logic [7:0] fetch_data;
   logic [3:0] stall = 4'h0;
   int n_mismatch = 0;
   int tests_run = 0;

   // Free-running instruction clock, 100 ns period.
   always #50 clock = ~clock;

   virs_sequencer DUT (.clock(clock), .reset(reset), .insn_boundary(insn_boundary),
      .skip_due(skip_due), .next_pc(next_pc), .boot_rom_exec(boot_rom_exec),
      .isp_active(isp_active), .src_event(src_event), .pend_clear(pend_clear),
      .enable_wr(enable_wr), .enable_data(enable_data), .status_wr(status_wr),
      .status_gie_data(status_gie_data), .trap_event(trap_event),
      .trap_pend_clear(trap_pend_clear), .return_from_interrupt_exec(return_from_interrupt_exec), .pop_addr(pop_addr),
      .vsel_exec(vsel_exec), .vsel_pc(vsel_pc), .fetch_ack(fetch_ack),
      .fetch_data(fetch_data), .global_irq_enable(global_irq_enable), .pending(pending),
      .enable(enable), .trap_pending(trap_pending), .seq_busy(seq_busy),
      .push_req(push_req), .push_addr(push_addr), .pc_load(pc_load), .pc_value(pc_value),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr));

   virs_prog_mem mem (.clock(clock), .reset(reset), .stall(stall), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

   ////////////////////////////////////////////////////////////////////////////////
   // Table contents as the bench expects them, kept apart from the model.
   function automatic logic [7:0] rom(input logic [ADDR_W-1:0] a);
      return a[0] ? (a[7:0] ^ 8'h3c) : (a[7:0] | 8'h80);
   endfunction

   task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp,
                      input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Bounded wait for the program counter load; k counts edges waited.
   task automatic wait_load(output int k);
      k = 0;
      while (pc_load !== 1'b1 && k < 40) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask

   // Firmware tidy-up: clears every flag, the trap flag, enables and the global enable.
   task automatic clean;
      @(posedge clock);
      pend_clear <= '1;
      trap_pend_clear <= 1'b1;
      status_wr <= 1'b1;
      status_gie_data <= 1'b0;
      enable_wr <= 1'b1;
      enable_data <= '0;
      @(posedge clock);
      pend_clear <= '0;
      trap_pend_clear <= 1'b0;
      status_wr <= 1'b0;
      enable_wr <= 1'b0;
   endtask

   task automatic arm(input logic [13:0] en, input logic [13:0] ev, input logic g);
      @(posedge clock);
      enable_wr <= 1'b1;
      enable_data <= en;
      src_event <= ev;
      status_wr <= 1'b1;
      status_gie_data <= g;
      @(posedge clock);
      enable_wr <= 1'b0;
      src_event <= '0;
      status_wr <= 1'b0;
      #1;
      chk(15'(global_irq_enable), 15'(g), "status write");
   endtask

   task automatic boundary(input logic [ADDR_W-1:0] pc);
      @(posedge clock);
      insn_boundary <= 1'b1;
      next_pc <= pc;
      @(posedge clock);
      insn_boundary <= 1'b0;
      #1;
   endtask

   task automatic do_vsel(input logic [ADDR_W-1:0] pc, input logic [3:0] slot);
      logic [ADDR_W-1:0] tab;
      logic [7:0] hi;
      logic [7:0] lo;
      int k;
      tab = {pc[14:8] + 7'(pc[7:0] == 8'hff), 8'he0 + {3'h0, slot, 1'b0}};
      hi = rom(tab);
      lo = rom(tab + 15'h0001);
      @(posedge clock);
      vsel_exec <= 1'b1;
      vsel_pc <= pc;
      @(posedge clock);
      vsel_exec <= 1'b0;
      #1;
      chk(fetch_addr, tab, "table address");
      chk(15'(fetch_req), 15'h0001, "fetch request");
      wait_load(k);
      chk(pc_value, {hi[6:0], lo}, "vector target");
      chk(15'(fetch_req), 15'h0000, "fetch done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(posedge clock);
      #1;
      chk({global_irq_enable, pending}, 15'h0000, "reset flags");
      chk({trap_pending, enable}, 15'h0000, "reset enables");
      $display("Test reset done");
   endtask

   task automatic t_ack;
      int k;
      arm(14'h0004, 14'h0004, 1'b1);
      @(posedge clock);
      boot_rom_exec <= 1'b1;
      boundary(15'h1230);
      chk(15'(push_req), 15'h0000, "boot blocks");
      chk(15'(global_irq_enable), 15'h0001, "boot keeps enable");
      @(posedge clock);
      boot_rom_exec <= 1'b0;
      skip_due <= 1'b1;
      insn_boundary <= 1'b1;
      @(posedge clock);
      skip_due <= 1'b0;
      next_pc <= 15'h1234;
      #1;
      chk(15'(push_req), 15'h0000, "skip first");
      @(posedge clock);
      insn_boundary <= 1'b0;
      #1;
      chk(15'(push_req), 15'h0001, "push");
      chk(push_addr, 15'h1234, "return address");
      chk(15'(global_irq_enable), 15'h0000, "enable cleared");
      chk(15'(seq_busy), 15'h0001, "busy in acknowledge");
      wait_load(k);
      chk(15'(k), 15'(ACK_CYCLES), "acknowledge length");
      chk(15'(seq_busy), 15'h0000, "idle after load");
      chk(pc_value, ENTRY_ADDR, "entry address");
      $display("Test acknowledge done");
   endtask

   task automatic t_return_from_interrupt;
      int k;
      @(posedge clock);
      pend_clear <= 14'h0004;
      @(posedge clock);
      pend_clear <= '0;
      src_event <= 14'h0004;
      @(posedge clock);
      src_event <= '0;
      return_from_interrupt_exec <= 1'b1;
      pop_addr <= 15'h2345;
      @(posedge clock);
      return_from_interrupt_exec <= 1'b0;
      #1;
      chk(pc_value, 15'h2345, "return load");
      chk({pc_load, global_irq_enable}, 15'h0003, "return enable");
      boundary(15'h2345);
      chk(15'(push_req), 15'h0001, "repeat served");
      chk(push_addr, 15'h2345, "repeat return address");
      // Let the repeat acknowledge finish, since a select is refused while it runs.
      wait_load(k);
      chk(pc_value, ENTRY_ADDR, "repeat entry");
      $display("Test return done");
   endtask

   // Every maskable slot, with all lower slots pending too; stalls vary.
   task automatic t_vsel;
      for (int s = 1; s <= 14; s++) begin
         clean;
         stall <= 4'(s % 3);
         arm(14'((1 << s) - 1), 14'((1 << s) - 1), 1'b1);
         do_vsel({4'(s), 3'h1, (s == 5) ? 8'hff : 8'h40}, 4'(s));
      end
      clean;
      do_vsel(15'h01ff, 4'h0);
      $display("Test vector select done");
   endtask

   task automatic t_trap;
      int k;
      clean;
      arm(14'h3fff, 14'h3fff, 1'b1);
      @(posedge clock);
      trap_event <= 1'b1;
      @(posedge clock);
      trap_event <= 1'b0;
      wait_load(k);
      chk(15'(k), 15'(ACK_CYCLES), "trap acknowledge length");
      chk(15'(trap_pending), 15'h0001, "trap pending");
      chk(pc_value, ENTRY_ADDR, "trap entry");
      do_vsel(15'h0123, 4'hf);
      $display("Test trap done");
   endtask

   task automatic t_isp;
      clean;
      arm(14'h0000, 14'h0001, 1'b0);
      @(posedge clock);
      isp_active <= 1'b1;
      src_event <= 14'h0001;
      @(posedge clock);
      src_event <= '0;
      pend_clear <= 14'h0001;
      @(posedge clock);
      pend_clear <= '0;
      isp_active <= 1'b0;
      #1;
      chk(15'(pending), 15'h0000, "one event kept");
      arm(14'h0001, 14'h0001, 1'b0);
      boundary(15'h0400);
      chk(15'(push_req), 15'h0000, "no take, enable low");
      $display("Test isp done");
   endtask

   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      t_reset;
      t_ack;
      t_return_from_interrupt;
      t_vsel;
      t_trap;
      t_isp;
      print_verdict;
   end

   // Watchdog: the tests need well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      print_verdict;
   end
endmodule
`default_nettype wire
